// ---- rtl/boot_loader_pkg.sv ----
// Purpose: shared constants and carriers of the serial boot RAM loader
// Assumes: byte-wide serial frames, LSB first
// Notes: codes and map figures are kept once here
package boot_loader_pkg;
  localparam logic [7:0] SYNC_ACK = 8'h30;
  localparam logic [7:0] CMD_RAM_LOAD = 8'h10;
  localparam logic [7:0] ACK_OK = 8'h10;
  localparam logic [7:0] ACK_BAD = 8'h11;
  localparam logic [7:0] ACK_RX_ERR = 8'h18;
  localparam logic [3:0] LOW_RX_ERR = 4'h8;
  localparam logic [3:0] LOW_BAD_CMD = 4'h1;
  localparam logic [7:0] TX_IDLE = 8'hff;
  localparam logic [3:0] PREV_CMD_RST = 4'h0;
  localparam int PW_BYTES = 12;
  localparam int HDR_BYTES = 8;
  localparam logic [3:0] PW_LAST = 4'hb;
  localparam logic [3:0] HDR_LAST = 4'h7;
  localparam logic [31:0] FLASH_LO = 32'h4000_0000;
  localparam logic [31:0] FLASH_HI = 32'h4007_ffff;
  localparam logic [31:0] ROM_LO = 32'h1fc0_0000;
  localparam logic [31:0] ROM_HI = 32'h1fc0_1fff;
  localparam logic [31:0] PW_FLASH_LO = 32'h0000_03f4;
  localparam logic [31:0] RAM_LO = 32'hfffd_6000;
  localparam logic [31:0] RAM_HI = 32'hfffd_efff;
  localparam int RAM_AW = 16;
  localparam int RAM_DEPTH = 36864;
  localparam bit SYNC_IF_MODE = 1'b1;

  typedef struct packed {
    logic [31:0] flash_lo;
    logic [31:0] flash_hi;
    logic [31:0] rom_lo;
    logic [31:0] rom_hi;
  } mem_map_t;

  typedef struct packed {
    logic valid;
    logic isa32;
    logic [31:0] addr;
  } jump_t;

  typedef enum logic [3:0] {
    ST_INIT = 4'b0000,
    ST_RXEN = 4'b0001,
    ST_MODE = 4'b0010,
    ST_SYNC = 4'b0011,
    ST_CMD = 4'b0100,
    ST_REPLY = 4'b0101,
    ST_PW = 4'b0110,
    ST_PWSUM = 4'b0111,
    ST_HDR = 4'b1000,
    ST_DATA = 4'b1001,
    ST_DSUM = 4'b1010,
    ST_JUMP = 4'b1011
  } load_state_t;
endpackage

// ---- rtl/boot_ram.sv ----
// Purpose: on-chip RAM that receives the loaded block
// Assumes: one write port and one read port on the same clock
// Notes: read data come out of a register, one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module boot_ram
  import boot_loader_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_wr_en,
  input wire logic [RAM_AW-1:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic [RAM_AW-1:0] i_rd_addr,
  output logic [7:0] o_rd_data
);
  logic [7:0] mem [0:RAM_DEPTH-1];

  always_ff @(posedge i_ref_clk)
  begin
    if (i_wr_en)
    begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    o_rd_data <= mem[i_rd_addr];
  end
endmodule // boot_ram
`default_nettype wire

// ---- rtl/serial_boot_ram_loader.sv ----
// Purpose: single-boot serial loader that fills on-chip RAM and hands over a jump
// Assumes: the programming host clocks every byte with the shift clock and idles between bytes
// Notes: serial link logic runs on the shift clock; protocol logic runs on i_ref_clk
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - after reset release with strap low, start from boot memory, not flash
// - in single boot, flash at 0x4000_0000..0x4007_FFFF, boot memory at 0x1FC0_0000..
// - serial set to rising-edge shift, reception enabled, then 30H loaded to transmit
// - byte three is the command; RAM load is 10H
// - receive error before command ack answers x8H, upper nibble from previous command
// - synchronous operation skips every receive error check
// - valid RAM load command is echoed 10H and password checking starts
// - undefined command answers x1H, upper nibble from previous command
// - bytes five to sixteen compared with flash password bytes; mismatch flags error
// - data from byte 27 written to RAM at given start address for given count
// - receive error in data or data checksum answers 18H, back to command wait; code tests rx_err only at the checksum byte, not at data bytes
// - data plus checksum must sum to zero, else answer 11H, back to command wait
// - after 10H for the data, jump to the start address in 32-bit mode
// - ack bit 3 means receive error, bit 0 any other error, bits 1-2 zero
// - password stage ack is 11H on checksum or password mismatch
module serial_boot_ram_loader
  import boot_loader_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_serial_shift_clock,
  input wire logic i_serial_rx_data,
  output logic o_serial_tx_data,
  input wire logic i_boot_select_b,
  input wire logic i_bus_width_strap_a,
  input wire logic i_bus_width_strap_b,
  input wire logic [8*PW_BYTES-1:0] i_flash_password,
  input wire logic [RAM_AW-1:0] i_ram_rd_addr,
  output logic [7:0] o_ram_rd_data,
  output logic o_boot_from_rom,
  output logic [1:0] o_bus_width,
  output mem_map_t o_mem_map,
  output jump_t o_jump
);
  // link side: shift clock domain
  logic [2:0] bit_cnt_reg;
  logic [6:0] rx_shift_reg;
  logic [7:0] rx_byte_reg;
  logic rx_toggle_reg;
  logic [6:0] tx_shift_reg;
  logic tx_data_reg;

  // protocol side: reference clock domain
  logic [2:0] rx_sync_reg;
  logic [2:0] strap_meta_reg;
  logic [2:0] strap_sync_reg;
  logic [1:0] strap_taken_reg;
  logic boot_rom_reg;
  logic [1:0] bus_width_reg;
  mem_map_t mem_map_reg;
  logic rise_edge_reg;
  logic receive_enable_bit;
  logic [7:0] tx_word_reg;
  load_state_t state_reg;
  load_state_t after_reply_reg;
  logic [3:0] prev_cmd_hi_reg;
  logic [3:0] idx_reg;
  logic [7:0] sum_reg;
  logic pw_err_reg;
  logic addr_err_reg;
  logic [31:0] start_addr_reg;
  logic [15:0] count_reg;
  logic [15:0] left_reg;
  logic [RAM_AW-1:0] wr_addr_reg;
  logic wr_en_reg;
  logic [7:0] wr_data_reg;
  jump_t jump_reg;
  logic rx_event;
  logic [7:0] rx_byte;
  logic rx_err;
  logic [7:0] sum_next;
  logic [7:0] pw_ref;
  logic [31:0] ram_offset;

  // link logic is cleared straight from the reset pin: the shift clock is stopped during reset
  always_ff @(posedge i_serial_shift_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      bit_cnt_reg <= 3'h0;
      rx_shift_reg <= 7'h00;
      rx_byte_reg <= 8'h00;
      rx_toggle_reg <= 1'b0;
    end
    else
    begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      rx_shift_reg <= {i_serial_rx_data, rx_shift_reg[6:1]};
      if (bit_cnt_reg == 3'h7)
      begin
        rx_byte_reg <= {i_serial_rx_data, rx_shift_reg};
        rx_toggle_reg <= ~rx_toggle_reg;
      end
    end
  end

  // tx word is only rewritten between frames, so it is stable at the first edge of a frame
  always_ff @(posedge i_serial_shift_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      tx_shift_reg <= 7'h7f;
      tx_data_reg <= 1'b1;
    end
    else if (bit_cnt_reg == 3'h0)
    begin
      tx_data_reg <= tx_word_reg[0];
      tx_shift_reg <= tx_word_reg[7:1];
    end
    else
    begin
      tx_data_reg <= tx_shift_reg[0];
      tx_shift_reg <= {1'b1, tx_shift_reg[6:1]};
    end
  end

  assign o_serial_tx_data = tx_data_reg;

  // byte-done toggle crosses with two flops; third flop only feeds the edge compare
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      rx_sync_reg <= 3'h0;
    end
    else
    begin
      rx_sync_reg <= {rx_sync_reg[1:0], rx_toggle_reg};
    end
  end

  assign rx_event = (rx_sync_reg[2] != rx_sync_reg[1]) && receive_enable_bit && rise_edge_reg;
  assign rx_byte = rx_byte_reg;
  assign rx_err = 1'b0 & ~SYNC_IF_MODE;
  assign sum_next = sum_reg + rx_byte;
  assign pw_ref = i_flash_password[8*idx_reg +: 8];
  assign ram_offset = start_addr_reg - RAM_LO;

  // straps pass two flops, then are caught once after reset release
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      strap_meta_reg <= 3'h0;
      strap_sync_reg <= 3'h0;
      strap_taken_reg <= 2'h0;
      boot_rom_reg <= 1'b0;
      bus_width_reg <= 2'h0;
      mem_map_reg <= '0;
    end
    else
    begin
      strap_meta_reg <= {i_bus_width_strap_b, i_bus_width_strap_a, i_boot_select_b};
      strap_sync_reg <= strap_meta_reg;
      // capture waits until the second flop holds the pins, not its reset zeros
      strap_taken_reg <= {strap_taken_reg[0], 1'b1};
      if (!strap_taken_reg[1])
      begin
        boot_rom_reg <= 1'b0;
      end
      else if (mem_map_reg.rom_hi == 32'h0)
      begin
        boot_rom_reg <= ~strap_sync_reg[0];
        bus_width_reg <= strap_sync_reg[2:1];
        mem_map_reg.flash_lo <= FLASH_LO;
        mem_map_reg.flash_hi <= FLASH_HI;
        mem_map_reg.rom_lo <= ROM_LO;
        mem_map_reg.rom_hi <= ROM_HI;
      end
    end
  end

  assign o_boot_from_rom = boot_rom_reg;
  assign o_bus_width = bus_width_reg;
  assign o_mem_map = mem_map_reg;

  // loader sequence; every reply is queued for the frame after the byte that caused it
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      state_reg <= ST_INIT;
      after_reply_reg <= ST_CMD;
      rise_edge_reg <= 1'b0;
      receive_enable_bit <= 1'b0;
      tx_word_reg <= TX_IDLE;
      prev_cmd_hi_reg <= PREV_CMD_RST;
      idx_reg <= 4'h0;
      sum_reg <= 8'h00;
      pw_err_reg <= 1'b0;
      addr_err_reg <= 1'b0;
      start_addr_reg <= 32'h0;
      count_reg <= 16'h0;
      left_reg <= 16'h0;
      jump_reg <= '0;
    end
    else
    begin
      case (state_reg)
        ST_INIT:
        begin
          if (boot_rom_reg)
          begin
            rise_edge_reg <= 1'b1;
            state_reg <= ST_RXEN;
          end
        end
        ST_RXEN:
        begin
          receive_enable_bit <= 1'b1;
          tx_word_reg <= SYNC_ACK;
          state_reg <= ST_MODE;
        end
        ST_MODE:
        begin
          if (rx_event)
          begin
            tx_word_reg <= SYNC_ACK;
            state_reg <= ST_SYNC;
          end
        end
        ST_SYNC:
        begin
          if (rx_event)
          begin
            tx_word_reg <= TX_IDLE;
            state_reg <= ST_CMD;
          end
        end
        ST_CMD:
        begin
          if (rx_event)
          begin
            prev_cmd_hi_reg <= rx_byte[7:4];
            state_reg <= ST_REPLY;
            if (rx_err)
            begin
              tx_word_reg <= {prev_cmd_hi_reg, LOW_RX_ERR};
              after_reply_reg <= ST_CMD;
            end
            else if (rx_byte == CMD_RAM_LOAD)
            begin
              tx_word_reg <= ACK_OK;
              after_reply_reg <= ST_PW;
            end
            else
            begin
              tx_word_reg <= {prev_cmd_hi_reg, LOW_BAD_CMD};
              after_reply_reg <= ST_CMD;
            end
          end
        end
        ST_REPLY:
        begin
          if (rx_event)
          begin
            tx_word_reg <= TX_IDLE;
            idx_reg <= 4'h0;
            sum_reg <= 8'h00;
            state_reg <= after_reply_reg;
            if (after_reply_reg == ST_PW)
            begin
              pw_err_reg <= 1'b0;
            end
            if (after_reply_reg == ST_JUMP)
            begin
              jump_reg.valid <= 1'b1;
              jump_reg.isa32 <= 1'b1;
              jump_reg.addr <= start_addr_reg;
            end
          end
        end
        ST_PW:
        begin
          if (rx_event)
          begin
            sum_reg <= sum_next;
            if (rx_byte != pw_ref)
            begin
              pw_err_reg <= 1'b1;
            end
            idx_reg <= idx_reg + 4'h1;
            if (idx_reg == PW_LAST)
            begin
              state_reg <= ST_PWSUM;
            end
          end
        end
        ST_PWSUM:
        begin
          if (rx_event)
          begin
            state_reg <= ST_REPLY;
            if (sum_next != 8'h00 || pw_err_reg)
            begin
              tx_word_reg <= ACK_BAD;
              after_reply_reg <= ST_CMD;
            end
            else
            begin
              tx_word_reg <= ACK_OK;
              after_reply_reg <= ST_HDR;
            end
          end
        end
        ST_HDR:
        begin
          if (rx_event)
          begin
            idx_reg <= idx_reg + 4'h1;
            if (idx_reg < 4'h4)
            begin
              start_addr_reg <= {start_addr_reg[23:0], rx_byte};
            end
            else if (idx_reg < 4'h6)
            begin
              count_reg <= {count_reg[7:0], rx_byte};
            end
            if (idx_reg == HDR_LAST)
            begin
              // bytes 25 and 26 fall through here unused
              left_reg <= count_reg;
              addr_err_reg <= (start_addr_reg < RAM_LO) || (start_addr_reg > RAM_HI);
              sum_reg <= 8'h00;
              state_reg <= (count_reg == 16'h0) ? ST_DSUM : ST_DATA;
            end
          end
        end
        ST_DATA:
        begin
          if (rx_event)
          begin
            sum_reg <= sum_next;
            left_reg <= left_reg - 16'h1;
            if (left_reg == 16'h1)
            begin
              state_reg <= ST_DSUM;
            end
          end
        end
        ST_DSUM:
        begin
          if (rx_event)
          begin
            state_reg <= ST_REPLY;
            after_reply_reg <= ST_CMD;
            if (rx_err)
            begin
              tx_word_reg <= ACK_RX_ERR;
            end
            else if (sum_next != 8'h00 || addr_err_reg)
            begin
              tx_word_reg <= ACK_BAD;
            end
            else
            begin
              tx_word_reg <= ACK_OK;
              after_reply_reg <= ST_JUMP;
            end
          end
        end
        ST_JUMP:
        begin
          // loader is finished; only a reset leaves this state
          state_reg <= ST_JUMP;
        end
        default:
        begin
          state_reg <= ST_INIT;
        end
      endcase
    end
  end

  assign o_jump = jump_reg;

  // RAM write path; bytes outside the RAM window are dropped, the final ack reports only a start address outside it
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      wr_en_reg <= 1'b0;
      wr_data_reg <= 8'h00;
      wr_addr_reg <= '0;
    end
    else
    begin
      wr_en_reg <= 1'b0;
      if (state_reg == ST_HDR && rx_event && idx_reg == HDR_LAST)
      begin
        wr_addr_reg <= ram_offset[RAM_AW-1:0];
      end
      if (state_reg == ST_DATA && rx_event)
      begin
        wr_en_reg <= ~addr_err_reg && (ram_offset + {16'h0, count_reg - left_reg} <= RAM_HI - RAM_LO);
        wr_data_reg <= rx_byte;
      end
      if (wr_en_reg)
      begin
        wr_addr_reg <= wr_addr_reg + {{(RAM_AW-1){1'b0}}, 1'b1};
      end
    end
  end

  boot_ram u_boot_ram (
    .i_ref_clk(i_ref_clk),
    .i_wr_en(wr_en_reg),
    .i_wr_addr(wr_addr_reg),
    .i_wr_data(wr_data_reg),
    .i_rd_addr(i_ram_rd_addr),
    .o_rd_data(o_ram_rd_data)
  );
endmodule // serial_boot_ram_loader
`default_nettype wire

// ---- test/boot_loader_chk.sv ----
// Purpose: port checker for the serial boot RAM loader
// Assumes: straps stay static after reset
// Notes: ref clock domain only; link bits are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module boot_loader_chk
  import boot_loader_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_serial_shift_clock,
  input wire logic i_boot_select_b,
  input wire logic i_bus_width_strap_a,
  input wire logic i_bus_width_strap_b,
  input wire logic o_boot_from_rom,
  input wire logic [1:0] o_bus_width,
  input wire mem_map_t o_mem_map,
  input wire jump_t o_jump
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_b);
  logic [7:0] idle_reg;
  // ref cycles since the shift clock was last seen high; saturates so it never wraps
  always_ff @(posedge i_ref_clk)
  begin
    if (i_serial_shift_clock)
      idle_reg <= 8'h00;
    else if (idle_reg != 8'hff)
      idle_reg <= idle_reg + 8'h01;
  end
  sequence s_strap_low_release;
    $rose(i_rst_b) ##0 !i_boot_select_b;
  endsequence
  sequence s_jump_taken;
    $rose(o_jump.valid);
  endsequence
  rom_select_a: assert property (s_strap_low_release |-> ##[1:8] o_boot_from_rom)
    else $error("boot memory not selected");
  rom_hold_a: assert property (o_boot_from_rom |=> o_boot_from_rom)
    else $error("boot select dropped");
  map_value_a: assert property ((o_mem_map != '0) |-> o_mem_map == {FLASH_LO, FLASH_HI, ROM_LO, ROM_HI})
    else $error("memory map wrong");
  map_rom_a: assert property ($rose(o_boot_from_rom) |-> ##[0:4] (o_mem_map.rom_hi == ROM_HI))
    else $error("memory map late");
  width_copy_a: assert property (o_boot_from_rom |=> o_bus_width == {i_bus_width_strap_b, i_bus_width_strap_a})
    else $error("bus width not copied");
  jump_hold_a: assert property (o_jump.valid |=> o_jump.valid && $stable(o_jump.addr))
    else $error("jump not held");
  jump_mode_a: assert property (o_jump.valid |-> o_jump.isa32 && o_boot_from_rom && o_jump.addr >= RAM_LO
    && o_jump.addr <= RAM_HI)
    else $error("jump mode or target wrong");
  jump_cause_a: assert property (s_jump_taken |-> idle_reg < 8'h0c)
    else $error("jump without a frame");
endmodule // boot_loader_chk

bind serial_boot_ram_loader boot_loader_chk i_chk (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
  .i_serial_shift_clock(i_serial_shift_clock), .i_boot_select_b(i_boot_select_b),
  .i_bus_width_strap_a(i_bus_width_strap_a), .i_bus_width_strap_b(i_bus_width_strap_b),
  .o_boot_from_rom(o_boot_from_rom), .o_bus_width(o_bus_width), .o_mem_map(o_mem_map), .o_jump(o_jump));
`default_nettype wire

// ---- test/host_model.sv ----
// Purpose: programming host that clocks byte frames into the loader
// Assumes: device shifts its reply bit after each rising edge
// Notes: clock stands low between frames
`timescale 1ns/1ps
`default_nettype none
module host_model
(
  input wire logic i_tx_data,
  output logic o_shift_clock,
  output logic o_rx_data
);
  initial
  begin
    o_shift_clock = 1'b0;
    o_rx_data = 1'b1;
  end
  // data set while the clock is low, reply bit taken at the falling edge
  task automatic xfer(input logic [7:0] b, input int hp, output logic [7:0] r);
    int k;
    for (k = 0; k < 8; k++)
    begin
      o_rx_data = b[k];
      #(hp);
      o_shift_clock = 1'b1;
      #(hp);
      r[k] = i_tx_data;
      o_shift_clock = 1'b0;
    end
    // released line shows the inverse so a stale bit never passes
    o_rx_data = ~b[7];
    #400;
  endtask
endmodule // host_model
`default_nettype wire

// ---- test/tb_top.sv ----
// Purpose: self-checking bench of the serial boot RAM loader
// Assumes: host frames at 64 ns link period (second sync byte at 1024 ns), no receive errors in this mode
// Notes: straps and flash password are static
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import boot_loader_pkg::*;
  logic clk, rst_b, sclk, rxd, txd, rom;
  logic [RAM_AW-1:0] rd_addr;
  logic [7:0] rd_data, r;
  logic [1:0] bw;
  mem_map_t map;
  jump_t jump;
  logic [8*PW_BYTES-1:0] pw;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  serial_boot_ram_loader i_serial_boot_ram_loader (.i_ref_clk(clk), .i_rst_b(rst_b), .i_serial_shift_clock(sclk),
    .i_serial_rx_data(rxd), .o_serial_tx_data(txd), .i_boot_select_b(1'b0), .i_bus_width_strap_a(1'b1),
    .i_bus_width_strap_b(1'b0), .i_flash_password(pw), .i_ram_rd_addr(rd_addr), .o_ram_rd_data(rd_data),
    .o_boot_from_rom(rom), .o_bus_width(bw), .o_mem_map(map), .o_jump(jump));
  host_model i_host_model (.i_tx_data(txd), .o_shift_clock(sclk), .o_rx_data(rxd));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // a hung handshake ends here instead of running forever
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      fails++;
      test_done();
    end
  end
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xb(input logic [7:0] b, output logic [7:0] q);
    i_host_model.xfer(b, 32, q);
  endtask
  task automatic t_boot();
    @(negedge clk);
    rst_b = 1'b0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    repeat (20) @(negedge clk);
    chk(rom, 1'b1);
    chk(bw, 2'b01);
    chk(map, {FLASH_LO, FLASH_HI, ROM_LO, ROM_HI});
    chk(jump.valid, 1'b0);
  endtask
  task automatic t_sync();
    logic [7:0] q;
    xb(8'h86, q);
    #2000;
    i_host_model.xfer(8'h00, 512, q);
    chk(q, SYNC_ACK);
  endtask
  task automatic t_load(input logic [7:0] first, input logic pw_bad, input logic [31:0] addr,
    input logic [7:0] dsx, input logic [7:0] exp_pw, input logic [7:0] exp_fin);
    logic [7:0] q, s, d;
    int i;
    xb(CMD_RAM_LOAD, q);
    chk(q, first);
    // the command ack is a frame of its own; the host byte in it is ignored
    xb(8'h00, q);
    chk(q, ACK_OK);
    s = 8'h00;
    for (i = 0; i < PW_BYTES; i++)
    begin
      d = pw[8*i+:8] ^ {7'h00, pw_bad && i == 11};
      s = s + d;
      xb(d, q);
    end
    xb(-s, q);
    xb(8'h00, q);
    chk(q, exp_pw);
    if (exp_pw != ACK_OK)
      return;
    for (i = 0; i < 4; i++)
      xb(addr[31-8*i-:8], q);
    xb(8'h00, q);
    xb(8'h04, q);
    xb(8'hee, q);
    xb(8'hee, q);
    s = 8'h00;
    for (i = 0; i < 4; i++)
    begin
      d = 8'h3c + 8'(i * 7);
      s = s + d;
      xb(d, q);
    end
    xb(-s ^ dsx, q);
    xb(8'h00, q);
    chk(q, exp_fin);
  endtask
  task automatic t_final(input logic [31:0] addr);
    int i;
    repeat (10) @(negedge clk);
    chk({jump.valid, jump.isa32, jump.addr}, {2'b11, addr});
    for (i = 0; i < 4; i++)
    begin
      rd_addr = 16'(addr - RAM_LO) + 16'(i);
      repeat (2) @(negedge clk);
      chk(rd_data, 8'h3c + 8'(i * 7));
    end
  endtask
  initial
  begin
    rst_b = 1'b0;
    rd_addr = '0;
    for (int k = 0; k < PW_BYTES; k++)
      pw[8*k+:8] = 8'ha0 + 8'(k);
    t_boot();
    t_sync();
    xb(8'h5a, r);
    xb(8'h00, r);
    chk(r, 8'h01);
    t_load(TX_IDLE, 1'b1, RAM_LO, 8'h00, ACK_BAD, ACK_OK);
    // second reset lands in command wait after the refused password
    t_boot();
    t_sync();
    t_load(TX_IDLE, 1'b0, RAM_HI + 32'h1, 8'h00, ACK_OK, ACK_BAD);
    t_load(TX_IDLE, 1'b0, RAM_LO, 8'h01, ACK_OK, ACK_BAD);
    xb(8'h77, r);
    xb(8'h00, r);
    chk(r, 8'h11);
    t_load(TX_IDLE, 1'b0, RAM_LO + 32'h10, 8'h00, ACK_OK, ACK_OK);
    t_final(RAM_LO + 32'h10);
    test_done();
  end
endmodule // tb_top
`default_nettype wire
